/* design/clock_gen_regs_pkg.sv */
// Register map constants for the clock generator configuration bank
package clock_gen_regs_pkg;

	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 8;
	localparam int NUM_BANKED = 17;

	localparam logic [11:0] ADDR_SERIAL_CFG  = 12'h000;
	localparam logic [11:0] ADDR_SILICON_REV = 12'h002;
	localparam logic [11:0] ADDR_PART_IDENTIFIER     = 12'h003;

	// Serial port configuration: upper nibble mirrors lower nibble
	localparam logic [7:0] SERIAL_CFG_RESET = 8'h00;
	localparam logic [7:0] SERIAL_CFG_MASK  = 8'he7;
	localparam logic [7:0] SOFT_RST_MASK    = 8'h24;
	localparam int         SDO_ACTIVE_HI    = 7;
	localparam int         SDO_ACTIVE_LO    = 0;
	localparam int         LSB_FIRST_HI     = 6;
	localparam int         LSB_FIRST_LO     = 1;

	// Banked register indices
	localparam int IDX_READBACK = 0;
	localparam int IDX_VER_LO   = 1;
	localparam int IDX_VER_HI   = 2;
	localparam int IDX_PUMP     = 3;
	localparam int IDX_REF_LO   = 4;
	localparam int IDX_REF_HI   = 5;
	localparam int IDX_SWALLOW  = 6;
	localparam int IDX_FB_LO    = 7;
	localparam int IDX_FB_HI    = 8;
	localparam int IDX_CTRL1    = 9;

	localparam logic [11:0] BANK_ADDR [NUM_BANKED] = '{
		12'h004, 12'h005, 12'h006, 12'h010, 12'h011, 12'h012, 12'h013, 12'h014, 12'h015,
		12'h016, 12'h017, 12'h018, 12'h019, 12'h01a, 12'h01b, 12'h01c, 12'h01d};
	localparam logic [7:0] BANK_RESET [NUM_BANKED] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00,
		8'h06, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
	localparam logic [7:0] BANK_MASK [NUM_BANKED] = '{
		8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfb};

	// Field positions
	localparam int READBACK_ACTIVE_BIT = 0;
	localparam int PD_POLARITY_BIT     = 7;
	localparam int PUMP_CURRENT_LSB    = 4;
	localparam int PUMP_MODE_LSB       = 2;
	localparam int PLL_PD_LSB          = 0;
	localparam int REF_DIV_W           = 14;
	localparam int SWALLOW_W           = 6;
	localparam int FEEDBACK_W          = 13;

endpackage : clock_gen_regs_pkg

/* design/bank_cell.sv */
// One register byte held as a buffered copy and an active copy
`timescale 1ns/1ps
module bank_cell
	import clock_gen_regs_pkg::*;
#(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] MASK      = 8'hff
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       soft_rst,
	input  wire logic       wr_en,
	input  wire logic       update,
	input  wire logic [7:0] wdata,
	output logic      [7:0] buf_q,
	output logic      [7:0] act_q
);

	if ((RESET_VAL & ~MASK) != 8'h00) begin : g_bad_reset
		$error("bank_cell reset value sets unused bits");
	end

	logic [7:0] buf_r;
	logic [7:0] act_r;

	always_ff @(posedge sys_clk) begin
		if (rst || soft_rst) begin
			buf_r <= RESET_VAL;
		end else if (wr_en) begin
			buf_r <= wdata & MASK;
		end
	end

	// Write and update in one cycle: active takes the older buffer value
	always_ff @(posedge sys_clk) begin
		if (rst || soft_rst) begin
			act_r <= RESET_VAL;
		end else if (update) begin
			act_r <= buf_r;
		end
	end

	assign buf_q = buf_r;
	assign act_q = act_r;

endmodule : bank_cell

/* design/clock_gen_config_register_bank.sv */
// Configuration register bank: serial port setup, IDs and PLL setup
// Operation
// - Writes to unmapped addresses are ignored and change no state.
// - Reference divider is fourteen bits split over two addresses, top bits unused.
// - Swallow counter is six bits in low bits, upper two unused.
// - Readback select bit picks active or buffered bank for reads.
// - Pump register holds polarity, pump current, pump mode and power-down fields.
// - Buffered bank copies into active bank only on an update event.
`timescale 1ns/1ps
module clock_gen_config_register_bank
	import clock_gen_regs_pkg::*;
#(
	parameter logic [7:0] SILICON_REV = 8'h5a,  // Arbitrary value
	parameter logic [7:0] PART_IDENTIFIER     = 8'ha5   // Arbitrary value
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  wr_en,
	input  wire logic                  rd_en,
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic                  io_update,
	output logic      [DATA_W-1:0]     rdata,
	output logic                       rd_valid,
	output logic                       sdo_active,
	output logic                       lsb_first,
	output logic                       phase_detector_polarity,
	output logic      [2:0]            pump_current,
	output logic      [1:0]            pump_mode,
	output logic      [1:0]            pll_power_down,
	output logic      [REF_DIV_W-1:0]  ref_divider,
	output logic      [SWALLOW_W-1:0]  swallow_count,
	output logic      [FEEDBACK_W-1:0] feedback_count,
	output logic      [7:0]            loop_control_one,
	output logic      [7:0]            loop_control_two,
	output logic      [7:0]            loop_control_three,
	output logic      [7:0]            loop_control_four,
	output logic      [7:0]            loop_control_five,
	output logic      [7:0]            loop_control_six,
	output logic      [7:0]            loop_control_seven,
	output logic      [7:0]            loop_control_eight
);

	logic [7:0]                serial_cfg_r;
	logic [7:0]                serial_cfg_nxt;
	logic                      soft_pend_r;
	logic [DATA_W-1:0]         rdata_r;
	logic [DATA_W-1:0]         rdata_nxt;
	logic                      rd_valid_r;
	logic [7:0]                buf_q    [NUM_BANKED];
	logic [7:0]                act_q    [NUM_BANKED];
	logic [NUM_BANKED-1:0]     bank_hit;
	logic [NUM_BANKED*8-1:0]   buf_vec;
	logic [NUM_BANKED*8-1:0]   act_vec;
	logic [NUM_BANKED*8-1:0]   reset_vec;
	logic [7:0]                bank_rd;

	// The eight loop control outputs are the last eight banked bytes
	if (IDX_CTRL1 + 8 != NUM_BANKED) begin : g_bad_map
		$error("banked map must end with eight loop control bytes");
	end

	wire cfg_hit     = (addr == ADDR_SERIAL_CFG);
	wire cfg_wr      = wr_en && cfg_hit;
	wire soft_req    = cfg_wr && ((wdata & SOFT_RST_MASK) != 8'h00);
	wire addr_mapped = cfg_hit || (addr == ADDR_SILICON_REV) || (addr == ADDR_PART_IDENTIFIER)
		|| (bank_hit != '0);
	wire read_active = act_q[IDX_READBACK][READBACK_ACTIVE_BIT];

	// A soft reset in progress wins over any write in the same cycle
	genvar gi;
	for (gi = 0; gi < NUM_BANKED; gi++) begin : g_bank
		assign bank_hit[gi] = (addr == BANK_ADDR[gi]);
		bank_cell #(
			.RESET_VAL (BANK_RESET[gi]),
			.MASK      (BANK_MASK[gi])
		) u_cell (
			.sys_clk  (sys_clk),
			.rst      (rst),
			.soft_rst (soft_pend_r),
			.wr_en    (wr_en && bank_hit[gi]),
			.update   (io_update),
			.wdata    (wdata),
			.buf_q    (buf_q[gi]),
			.act_q    (act_q[gi])
		);
		assign buf_vec[gi*8 +: 8]   = buf_q[gi];
		assign act_vec[gi*8 +: 8]   = act_q[gi];
		assign reset_vec[gi*8 +: 8] = BANK_RESET[gi];
	end

	// Serial config acts at once; soft reset bits shown for one cycle only
	// Showing them lets a host see that the request was taken before it clears
	always_comb begin
		serial_cfg_nxt = serial_cfg_r;
		if (soft_pend_r) begin
			serial_cfg_nxt = SERIAL_CFG_RESET;
		end else if (cfg_wr) begin
			serial_cfg_nxt = wdata & SERIAL_CFG_MASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			serial_cfg_r <= SERIAL_CFG_RESET;
			soft_pend_r  <= 1'b0;
		end else begin
			serial_cfg_r <= serial_cfg_nxt;
			soft_pend_r  <= soft_req && !soft_pend_r;
		end
	end

	// Read path: banked registers follow the readback select bit
	// Unmapped reads still answer, with zero, so a polling host never stalls
	always_comb begin
		bank_rd = 8'h00;
		for (int i = 0; i < NUM_BANKED; i++) begin
			if (bank_hit[i]) begin
				bank_rd = read_active ? act_q[i] : buf_q[i];
			end
		end
	end

	assign rdata_nxt = cfg_hit                     ? serial_cfg_r :
			   (addr == ADDR_SILICON_REV) ? SILICON_REV  :
			   (addr == ADDR_PART_IDENTIFIER)     ? PART_IDENTIFIER      : bank_rd;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_r    <= 8'h00;
			rd_valid_r <= 1'b0;
		end else begin
			rdata_r    <= rd_en ? rdata_nxt : 8'h00;
			rd_valid_r <= rd_en;
		end
	end

	assign rdata    = rdata_r;
	assign rd_valid = rd_valid_r;

	// Mirrored bit pairs: either copy enables the function
	assign sdo_active = serial_cfg_r[SDO_ACTIVE_HI] | serial_cfg_r[SDO_ACTIVE_LO];
	assign lsb_first  = serial_cfg_r[LSB_FIRST_HI] | serial_cfg_r[LSB_FIRST_LO];

	// PLL fields always come from the active bank
	assign phase_detector_polarity = act_q[IDX_PUMP][PD_POLARITY_BIT];
	assign pump_current   = act_q[IDX_PUMP][PUMP_CURRENT_LSB +: 3];
	assign pump_mode      = act_q[IDX_PUMP][PUMP_MODE_LSB +: 2];
	assign pll_power_down = act_q[IDX_PUMP][PLL_PD_LSB +: 2];
	assign ref_divider    = {act_q[IDX_REF_HI][5:0], act_q[IDX_REF_LO]};
	assign swallow_count  = act_q[IDX_SWALLOW][SWALLOW_W-1:0];
	assign feedback_count = {act_q[IDX_FB_HI][4:0], act_q[IDX_FB_LO]};
	assign loop_control_one   = act_q[IDX_CTRL1];
	assign loop_control_two   = act_q[IDX_CTRL1+1];
	assign loop_control_three = act_q[IDX_CTRL1+2];
	assign loop_control_four  = act_q[IDX_CTRL1+3];
	assign loop_control_five  = act_q[IDX_CTRL1+4];
	assign loop_control_six   = act_q[IDX_CTRL1+5];
	assign loop_control_seven = act_q[IDX_CTRL1+6];
	assign loop_control_eight = act_q[IDX_CTRL1+7];

	// Checks
	wire pump_hit = (addr == BANK_ADDR[IDX_PUMP]);

	AST_UNMAPPED_WRITE: assert property (
		@(posedge sys_clk) disable iff (rst)
		(wr_en && !addr_mapped && !soft_pend_r)
			|=> ($stable(buf_vec) && $stable(serial_cfg_r)))
		else $error("unmapped write changed register state");

	AST_REF_DIVIDER: assert property (
		@(posedge sys_clk) disable iff (rst)
		(buf_q[IDX_REF_HI][7:6] == 2'b00) && (act_q[IDX_REF_HI][7:6] == 2'b00)
			&& (ref_divider[REF_DIV_W-1:8] == act_q[IDX_REF_HI][5:0]))
		else $error("reference divider upper bits wrong");

	AST_SWALLOW_WIDTH: assert property (
		@(posedge sys_clk) disable iff (rst)
		(wr_en && bank_hit[IDX_SWALLOW] && !soft_pend_r)
			|=> (buf_q[IDX_SWALLOW] == {2'b00, $past(wdata[SWALLOW_W-1:0])}))
		else $error("swallow counter not six bits wide");

	AST_READBACK_SEL: assert property (
		@(posedge sys_clk) disable iff (rst)
		(rd_en && pump_hit)
			|=> (rdata == ($past(read_active) ? $past(act_q[IDX_PUMP])
				: $past(buf_q[IDX_PUMP]))))
		else $error("readback returned wrong bank");

	sequence s_pump_write;
		wr_en && pump_hit && !soft_pend_r && !io_update;
	endsequence

	sequence s_clean_update;
		io_update && !soft_pend_r;
	endsequence

	AST_PUMP_FIELDS: assert property (
		@(posedge sys_clk) disable iff (rst)
		(s_pump_write ##1 s_clean_update)
			|=> ({phase_detector_polarity, pump_current, pump_mode, pll_power_down}
				== $past(wdata, 2)))
		else $error("pump fields not loaded by update");

	// Every update outside a soft reset copies the whole buffered bank, not only the pump byte
	AST_UPDATE_COPY: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_clean_update |=> (act_vec == $past(buf_vec)))
		else $error("update did not copy the buffered bank");

	AST_SOFT_WINS: assert property (
		@(posedge sys_clk) disable iff (rst)
		soft_pend_r |=> ((buf_vec == reset_vec) && (act_vec == reset_vec)))
		else $error("write or update landed during soft reset");

	AST_NO_EARLY_EFFECT: assert property (
		@(posedge sys_clk) disable iff (rst)
		(!io_update && !soft_pend_r) |=> $stable(act_vec))
		else $error("active bank changed without update");

	sequence s_soft_request;
		soft_req && !soft_pend_r;
	endsequence

	AST_SOFT_CLEAR: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_soft_request |=> ((serial_cfg_r & SOFT_RST_MASK) != 8'h00)
			##1 ((serial_cfg_r == SERIAL_CFG_RESET) && (buf_vec == reset_vec)
				&& (act_vec == reset_vec)))
		else $error("soft reset did not complete and clear");

endmodule : clock_gen_config_register_bank

/* tb/host_model.sv */
// Host controller model on the register port
`timescale 1ns/1ps
module host_model
	import clock_gen_regs_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic [DATA_W-1:0] rdata,
	input  wire logic              rd_valid,
	output logic                   wr_en,
	output logic                   rd_en,
	output logic      [ADDR_W-1:0] addr,
	output logic      [DATA_W-1:0] wdata,
	output logic                   io_update
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 12'h000;
		wdata = 8'h00;
		io_update = 1'b0;
	end
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d & m;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		// Released lines show junk, not the last value
		wdata <= ~(d & m);
		addr <= ~a;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic v);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
		v = rd_valid;
	endtask : rd
	task automatic upd();
		@(posedge sys_clk);
		io_update <= 1'b1;
		@(posedge sys_clk);
		io_update <= 1'b0;
		#1;
	endtask : upd
	// Write, then update on the next edge, or on the same edge when same is set
	task automatic wr_upd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m,
		input logic same);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d & m;
		io_update <= same;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		wdata <= ~(d & m);
		addr <= ~a;
		io_update <= !same;
		@(posedge sys_clk);
		io_update <= 1'b0;
		#1;
	endtask : wr_upd
endmodule : host_model

/* tb/testbench.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module testbench
	import clock_gen_regs_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr_en, rd_en, io_update, rd_valid, sdo, lsbf, pol, v;
	logic [11:0] addr;
	logic [7:0]  wdata, rdata, d;
	logic [2:0]  pcur;
	logic [1:0]  pmode, ppd;
	logic [13:0] rdiv;
	logic [5:0]  swc;
	logic [12:0] fbc;
	logic [7:0]  lc [8];
	logic [7:0]  bm [NUM_BANKED];
	logic [7:0]  am [NUM_BANKED];
	logic [31:0] seed = 32'h5a55f28f;
	logic [11:0] unmapped [5] = '{12'h001, 12'h007, 12'h00f, 12'h400, 12'hfff};
	int          fail_count = 0;
	int          n_tests = 0;

	always #2.5 sys_clk = ~sys_clk;

	host_model host (.sys_clk(sys_clk), .rdata(rdata), .rd_valid(rd_valid), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata), .io_update(io_update));

	clock_gen_config_register_bank dut (.sys_clk(sys_clk), .rst(rst), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata), .io_update(io_update), .rdata(rdata),
		.rd_valid(rd_valid), .sdo_active(sdo), .lsb_first(lsbf),
		.phase_detector_polarity(pol), .pump_current(pcur), .pump_mode(pmode),
		.pll_power_down(ppd), .ref_divider(rdiv), .swallow_count(swc),
		.feedback_count(fbc), .loop_control_one(lc[0]), .loop_control_two(lc[1]),
		.loop_control_three(lc[2]), .loop_control_four(lc[3]), .loop_control_five(lc[4]),
		.loop_control_six(lc[5]), .loop_control_seven(lc[6]), .loop_control_eight(lc[7]));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic stop_test();
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic mreset();
		for (int i = 0; i < NUM_BANKED; i++) begin
			bm[i] = BANK_RESET[i];
			am[i] = BANK_RESET[i];
		end
	endtask : mreset

	// Reads follow the active copy of the readback select bit
	task automatic rd_all();
		for (int i = 0; i < NUM_BANKED; i++) begin
			host.rd(BANK_ADDR[i], d, v);
			chk("rdvalid", 16'h1, {15'h0, v});
			chk("rdata", am[IDX_READBACK][0] ? am[i] : bm[i], d);
		end
	endtask : rd_all

	task automatic out_all();
		chk("polarity", am[IDX_PUMP][7], pol);
		chk("pcur", am[IDX_PUMP][6:4], pcur);
		chk("pmode", am[IDX_PUMP][3:2], pmode);
		chk("pdown", am[IDX_PUMP][1:0], ppd);
		chk("rdiv", {am[IDX_REF_HI][5:0], am[IDX_REF_LO]}, rdiv);
		chk("swallow", am[IDX_SWALLOW][5:0], swc);
		chk("fb", {am[IDX_FB_HI][4:0], am[IDX_FB_LO]}, fbc);
		for (int k = 0; k < 8; k++) begin
			chk("loopctl", am[IDX_CTRL1 + k], lc[k]);
		end
	endtask : out_all

	initial begin
		#100000;
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		mreset();
		rd_all();
		out_all();
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < NUM_BANKED; i++) begin
				seed = lfsr(seed);
				host.wr(BANK_ADDR[i], seed[7:0], BANK_MASK[i]);
				bm[i] = seed[7:0] & BANK_MASK[i];
			end
			#1;
			out_all();
			rd_all();
			host.upd();
			am = bm;
			out_all();
			rd_all();
		end
		// Force both readback settings against differing copies
		for (int s = 0; s < 2; s++) begin
			host.wr(BANK_ADDR[IDX_READBACK], s[7:0], 8'h01);
			bm[IDX_READBACK] = s[7:0];
			host.upd();
			am = bm;
			host.wr(BANK_ADDR[IDX_PUMP], ~am[IDX_PUMP], 8'hff);
			bm[IDX_PUMP] = ~am[IDX_PUMP];
			rd_all();
		end
		// Write then update on the next edge, then both on one edge
		seed = lfsr(seed);
		host.wr_upd(BANK_ADDR[IDX_PUMP], seed[7:0], 8'hff, 1'b0);
		bm[IDX_PUMP] = seed[7:0];
		am = bm;
		out_all();
		seed = lfsr(seed);
		host.wr_upd(BANK_ADDR[IDX_PUMP], seed[7:0], 8'hff, 1'b1);
		am = bm;
		bm[IDX_PUMP] = seed[7:0];
		out_all();
		rd_all();
		// Unmapped places leave no trace and read zero; unused ones only get zero
		for (int j = 0; j < 5; j++) begin
			host.wr(unmapped[j], 8'hff, (j < 3) ? 8'h00 : 8'hff);
			host.rd(unmapped[j], d, v);
			chk("unmapped", 16'h0, d);
		end
		host.upd();
		am = bm;
		rd_all();
		out_all();
		host.wr(ADDR_SERIAL_CFG, 8'h42, SERIAL_CFG_MASK);
		#1;
		chk("lsbfirst", 16'h1, {15'h0, lsbf});
		chk("sdo", 16'h0, {15'h0, sdo});
		host.wr(ADDR_SERIAL_CFG, 8'h81, SERIAL_CFG_MASK);
		#1;
		chk("sdo", 16'h1, {15'h0, sdo});
		chk("lsbfirst", 16'h0, {15'h0, lsbf});
		host.wr(ADDR_SERIAL_CFG, 8'h24, SERIAL_CFG_MASK);
		mreset();
		host.rd(ADDR_SERIAL_CFG, d, v);
		chk("softrst", 16'h0, d);
		rd_all();
		out_all();
		stop_test();
	end
endmodule : testbench
